// ---- hw/mcs_pkg.sv ----
// package: constants and types for the memory channel event selector
package mcs_pkg;

   // ----------------------------------------------------------------
   // register byte offsets (apb, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] MCS_OFF_CTL0 = 8'h00;   // ctl0..ctl3 at +4 each
   localparam logic [7:0] MCS_OFF_CNT0 = 8'h10;   // cnt0..cnt3 at +4 each
   localparam logic [7:0] MCS_OFF_STATUS = 8'h20; // overflow flags, w1c
   localparam logic [7:0] MCS_OFF_MASK = 8'h24;   // interrupt mask

   // ----------------------------------------------------------------
   // counter control field layout
   // ----------------------------------------------------------------
   localparam int MCS_EV_LSB = 0;
   localparam int MCS_UM_LSB = 8;
   localparam int MCS_EDGE_BIT = 18;
   localparam int MCS_EN_BIT = 22;
   localparam int MCS_INV_BIT = 23;
   localparam logic [31:0] MCS_CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] MCS_CTL_WMASK = 32'h00c4_ffff;
   localparam logic [3:0] MCS_STATUS_RESET = 4'h0;
   localparam logic [3:0] MCS_MASK_RESET = 4'h0;

   // ----------------------------------------------------------------
   // event codes
   // ----------------------------------------------------------------
   localparam logic [7:0] MCS_EV_COL_BY_MODE = 8'h04;
   localparam logic [7:0] MCS_EV_PRE_ALL = 8'h44;
   localparam logic [7:0] MCS_EV_REFRESH = 8'h45;
   localparam logic [7:0] MCS_EV_MODE_CYCLES = 8'h07;
   localparam logic [7:0] MCS_EV_TRANS_ZERO = 8'h50;
   localparam logic [7:0] MCS_EV_TRANS_ONE = 8'h51;
   localparam logic [7:0] MCS_EV_PM_CMD_SUB0 = 8'hea;
   localparam logic [7:0] MCS_EV_PM_CMD_SUB1 = 8'heb;
   localparam logic [7:0] MCS_EV_PM_RDQ_ALLOC = 8'he3;
   localparam logic [7:0] MCS_EV_PM_RDQ_FILL = 8'he0;
   localparam logic [7:0] MCS_EV_PM_WRQ_ALLOC = 8'he7;
   localparam logic [7:0] MCS_EV_PM_WRQ_FILL = 8'he4;
   localparam logic [7:0] MCS_EV_CKE_CYCLES = 8'h47;

   // ----------------------------------------------------------------
   // major modes, in unit-mask bit order
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      mcs_pref_rd,
      mcs_starved_rd,
      mcs_pref_wr,
      mcs_starved_wr
   } mcs_mode_t;

endpackage : mcs_pkg

// ---- hw/mcs_event_select.sv ----
// module: event selection, qualification and counting for a memory channel monitor
`timescale 1ns/100ps

// Operation
// - all events usable on counters 0-3, unit mask in control bits 15:8
// - code 0x4 counts read/write column commands per major mode and pseudo channel
// - code 0x44 counts precharge-all; mask bit 0 channel zero, bit 1 channel one
// - code 0x45 counts refreshes; panic ch0 bit 1, panic ch1 bit 4, high ch1 bit 5
// - code 0x7 counts cycles in masked major mode, bits 0-3 pr, sr, pw, sw
// - one major-mode state per channel; residency follows that channel-wide state
// - code 0x50 counts eight selectable major-mode transitions on pseudo channel zero
// - code 0x51 counts the same eight transitions on pseudo channel one
// - code 0xea counts persistent-memory commands on sub-channel zero, mask selected
// - code 0xeb counts sub-channel-one persistent-memory occurrences, mask selected
// - code 0xe3 counts read queue allocations, isochronous and not
// - code 0xe0 adds masked read queue occupancy every cycle
// - code 0xe7 counts write queue allocations
// - code 0xe4 adds masked write queue occupancy every cycle
// - code 0x47 counts cycles a masked rank has clock enable on, at most one
// - all power-down variants count alike as clock-enable-off cycles
module mcs_event_select
   import mcs_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int OCC_W = 6
)
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic o_irq,
   // scheduler conditions: modes two bits each, the rest one bit per pseudo channel
   input wire logic [1:0] i_mode_ch0,
   input wire logic [1:0] i_mode_ch1,
   input wire logic [1:0] i_col_rd,
   input wire logic [1:0] i_col_wr,
   input wire logic [1:0] i_pre_all,
   input wire logic [1:0] i_ref_panic,
   input wire logic [1:0] i_ref_high,
   // persistent memory conditions
   input wire logic [7:0] i_pm_cmd_sub0,
   input wire logic [7:0] i_pm_cmd_sub1,
   input wire logic i_pm_rd_alloc_isochronous_request,
   input wire logic i_pm_rd_alloc_norm,
   input wire logic i_pm_wr_alloc,
   input wire logic [6*OCC_W-1:0] i_pm_rdq_fill,
   input wire logic [6*OCC_W-1:0] i_pm_wrq_fill,
   // rank clock-enable levels
   input wire logic [3:0] i_cke_on
);

   localparam int SUM_W = OCC_W + 3;
   localparam int NCNT = 4;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // transition one-hot in unit-mask order
   function automatic logic [7:0] trans_vec(input logic [1:0] p, input logic [1:0] c);
      logic [7:0] v;
      v = 8'h00;
      v[0] = (p == mcs_pref_rd) && (c == mcs_starved_wr);
      v[1] = (p == mcs_pref_rd) && (c == mcs_pref_wr);
      v[2] = (p == mcs_starved_wr) && (c == mcs_pref_rd);
      v[3] = (p == mcs_starved_wr) && (c == mcs_pref_wr);
      v[4] = (p == mcs_starved_rd) && (c == mcs_pref_rd);
      v[5] = (p == mcs_starved_rd) && (c == mcs_pref_wr);
      v[6] = (p == mcs_pref_wr) && (c == mcs_starved_rd);
      v[7] = (p == mcs_pref_wr) && (c == mcs_pref_rd);
      return v;
   endfunction : trans_vec

   // sum of occupancy fields picked by mask bits 0..5
   function automatic logic [SUM_W-1:0] fill_sum(input logic [7:0] m, input logic [6*OCC_W-1:0] f);
      logic [SUM_W-1:0] s;
      s = '0;
      for (int i = 0; i < 6; i++)
      begin
         if (m[i])
            s = s + SUM_W'(f[i*OCC_W +: OCC_W]);
      end
      return s;
   endfunction : fill_sum

   // ----------------------------------------------------------------
   // major-mode tracking
   // ----------------------------------------------------------------
   logic [1:0] mode_prev0;
   logic [1:0] mode_prev1;

   // previous mode per pseudo channel, for transition detection
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         mode_prev0 <= mcs_pref_rd;
         mode_prev1 <= mcs_pref_rd;
      end
      else if (i_clk_en)
      begin
         mode_prev0 <= i_mode_ch0;
         mode_prev1 <= i_mode_ch1;
      end
   end

   // ----------------------------------------------------------------
   // condition vectors, one bit per unit-mask position
   // ----------------------------------------------------------------
   wire rmm0 = ~i_mode_ch0[1];   // read modes encode with msb clear
   wire rmm1 = ~i_mode_ch1[1];
   wire [7:0] v_col_mode;
   wire [7:0] v_pre_all;
   wire [7:0] v_refresh;
   wire [7:0] v_mode_cyc;
   wire [7:0] v_trans0;
   wire [7:0] v_trans1;
   wire [7:0] v_cke;
   wire c_rd_alloc;

   // column commands split by the mode of their own pseudo channel
   assign v_col_mode = {i_col_wr[1] & ~rmm1, i_col_wr[1] & rmm1,
                        i_col_wr[0] & ~rmm0, i_col_wr[0] & rmm0,
                        i_col_rd[1] & ~rmm1, i_col_rd[1] & rmm1,
                        i_col_rd[0] & ~rmm0, i_col_rd[0] & rmm0};
   assign v_pre_all = {6'h00, i_pre_all};
   // bit 2 carries high-priority on channel zero, implied by the combined mask
   assign v_refresh = {2'b00, i_ref_high[1], i_ref_panic[1], 1'b0,
                       i_ref_high[0], i_ref_panic[0], 1'b0};
   // residency follows the channel-wide mode, held on pseudo channel zero
   assign v_mode_cyc = {4'h0, 4'(1 << i_mode_ch0)};
   assign v_trans0 = trans_vec(mode_prev0, i_mode_ch0);
   assign v_trans1 = trans_vec(mode_prev1, i_mode_ch1);
   // one level per rank, power-down flavours are not told apart
   assign v_cke = {4'h0, i_cke_on};
   assign c_rd_alloc = i_pm_rd_alloc_isochronous_request | i_pm_rd_alloc_norm;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire acc = i_psel & i_penable;
   wire wr_done = acc & o_pready & i_pwrite;
   wire hit_ctl = (i_paddr[7:4] == MCS_OFF_CTL0[7:4]) & (i_paddr[1:0] == 2'b00);
   wire hit_cnt = (i_paddr[7:4] == MCS_OFF_CNT0[7:4]) & (i_paddr[1:0] == 2'b00);
   wire hit_st = (i_paddr == MCS_OFF_STATUS);
   wire hit_mk = (i_paddr == MCS_OFF_MASK);
   wire mapped = hit_ctl | hit_cnt | hit_st | hit_mk;
   wire [1:0] idx = i_paddr[3:2];

   logic [3:0] status;
   logic [3:0] irq_mask;
   wire [31:0] rd_ctl [NCNT];
   wire [CNT_W-1:0] rd_cnt [NCNT];
   wire [NCNT-1:0] ovf;
   wire [31:0] rd_mux;

   // read selection, unmapped reads return zero
   assign rd_mux = hit_ctl ? rd_ctl[idx] :
                   hit_cnt ? 32'(rd_cnt[idx]) :
                   hit_st ? {28'h0, status} :
                   hit_mk ? {28'h0, irq_mask} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NCNT; g++)
   begin : gen_ctr
      logic [31:0] ctl;
      logic [CNT_W-1:0] cnt;
      logic lvl_prev;
      wire [7:0] ev = ctl[MCS_EV_LSB +: 8];
      wire [7:0] um = ctl[MCS_UM_LSB +: 8];
      wire wr_ctl = wr_done & hit_ctl & (idx == 2'(g));
      wire wr_cnt = wr_done & hit_cnt & (idx == 2'(g));
      wire is_occ;
      wire known;
      wire hit;
      wire lvl;
      wire one;
      wire [SUM_W-1:0] inc;
      wire [CNT_W:0] sum;

      // masked conditions are ored, so one increment per cycle at most
      assign hit = (ev == MCS_EV_COL_BY_MODE) ? |(um & v_col_mode) :
                   (ev == MCS_EV_PRE_ALL) ? |(um & v_pre_all) :
                   (ev == MCS_EV_REFRESH) ? |(um & v_refresh) :
                   (ev == MCS_EV_MODE_CYCLES) ? |(um & v_mode_cyc) :
                   (ev == MCS_EV_TRANS_ZERO) ? |(um & v_trans0) :
                   (ev == MCS_EV_TRANS_ONE) ? |(um & v_trans1) :
                   (ev == MCS_EV_PM_CMD_SUB0) ? |(um & i_pm_cmd_sub0) :
                   (ev == MCS_EV_PM_CMD_SUB1) ? |(um & i_pm_cmd_sub1) :
                   (ev == MCS_EV_PM_RDQ_ALLOC) ? c_rd_alloc :
                   (ev == MCS_EV_PM_WRQ_ALLOC) ? i_pm_wr_alloc :
                   (ev == MCS_EV_CKE_CYCLES) ? |(um & v_cke) : 1'b0;
      assign is_occ = (ev == MCS_EV_PM_RDQ_FILL) | (ev == MCS_EV_PM_WRQ_FILL);
      // known codes only, so invert cannot make an undefined code count
      assign known = is_occ | (ev == MCS_EV_COL_BY_MODE) | (ev == MCS_EV_PRE_ALL) |
                     (ev == MCS_EV_REFRESH) | (ev == MCS_EV_MODE_CYCLES) |
                     (ev == MCS_EV_TRANS_ZERO) | (ev == MCS_EV_TRANS_ONE) |
                     (ev == MCS_EV_PM_CMD_SUB0) | (ev == MCS_EV_PM_CMD_SUB1) |
                     (ev == MCS_EV_PM_RDQ_ALLOC) | (ev == MCS_EV_PM_WRQ_ALLOC) |
                     (ev == MCS_EV_CKE_CYCLES);
      // invert then edge; both together is left to software to avoid
      assign lvl = known & (hit ^ ctl[MCS_INV_BIT]);
      assign one = ctl[MCS_EDGE_BIT] ? (lvl & ~lvl_prev) : lvl;
      // occupancy adds the masked fields each cycle, ignoring invert and edge
      assign inc = ~ctl[MCS_EN_BIT] ? '0 :
                   (ev == MCS_EV_PM_RDQ_FILL) ? fill_sum(um, i_pm_rdq_fill) :
                   (ev == MCS_EV_PM_WRQ_FILL) ? fill_sum(um, i_pm_wrq_fill) :
                   SUM_W'(one);
      assign sum = {1'b0, cnt} + (CNT_W + 1)'(inc);
      assign ovf[g] = ~wr_cnt & sum[CNT_W];
      assign rd_ctl[g] = ctl;
      assign rd_cnt[g] = cnt;

      // control register
      always_ff @(posedge i_clock or posedge i_rst)
      begin
         if (i_rst)
            ctl <= MCS_CTL_RESET;
         else if (i_clk_en && wr_ctl)
            ctl <= i_pwdata & MCS_CTL_WMASK;
      end

      // counter; a software load wins over a same-cycle increment
      always_ff @(posedge i_clock or posedge i_rst)
      begin
         if (i_rst)
         begin
            cnt <= '0;
            lvl_prev <= 1'b0;
         end
         else if (i_clk_en)
         begin
            lvl_prev <= lvl;
            cnt <= wr_cnt ? i_pwdata[CNT_W-1:0] : sum[CNT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------
   wire [3:0] st_clr = (wr_done & hit_st) ? i_pwdata[3:0] : 4'h0;
   wire [3:0] next_status = (status & ~st_clr) | ovf;   // set beats clear

   // sticky overflow flags, mask and level interrupt
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         status <= MCS_STATUS_RESET;
         irq_mask <= MCS_MASK_RESET;
         o_irq <= 1'b0;
      end
      else if (i_clk_en)
      begin
         status <= next_status;
         if (wr_done & hit_mk)
            irq_mask <= i_pwdata[3:0];
         o_irq <= |(status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // apb answer: one wait state, data and error registered
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_pready <= acc & ~o_pready;
         o_pslverr <= acc & ~o_pready & ~mapped;
         o_prdata <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

endmodule : mcs_event_select

// ---- testbench/mcs_sva.sv ----
// checker: apb and interrupt timing at the selector ports
`timescale 1ns/100ps
module mcs_sva
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic o_irq
);
   // ------------------------------
   // port relations
   // ------------------------------
   // a frozen clock enable stretches everything, so it suspends checking
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst || !i_clk_en);
   AST_ACK_NEXT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("ready late");
   AST_ACK_ONE: assert property (o_pready |=> !o_pready)
      else $error("ready too long");
   AST_ACK_CAUSE: assert property (o_pready |-> $past(i_psel) && $past(i_penable))
      else $error("ready without access");
   AST_DATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   AST_ERR_QUAL: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   AST_ERR_MAP: assert property (o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 8'h24))
      else $error("error flag wrong for address");
   AST_CTL_BITS: assert property (o_pready && !i_pwrite && i_paddr < 8'h10 |-> (o_prdata & 32'hff3b_0000) == 32'h0)
      else $error("control reads undefined bits");
   AST_IRQ_OFF: assert property (o_pready && i_pwrite && i_paddr == 8'h24 && i_pwdata == 32'h0 |-> ##2 !o_irq)
      else $error("irq stays with mask clear");
endmodule : mcs_sva

bind mcs_event_select mcs_sva u_sva (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_irq(o_irq));

// ---- testbench/mcs_sched_model.sv ----
// model: scheduler and queue status source, conditions in bursts
`timescale 1ns/100ps
module mcs_sched_model
#(
   parameter int OCC_W = 6
)
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [7:0] i_pat,
   input wire logic [7:0] i_len,
   output logic o_busy,
   output logic [1:0] o_mode,
   output logic [1:0] o_rd,
   output logic [1:0] o_wr,
   output logic [7:0] o_pm,
   output logic [2:0] o_alloc,
   output logic [6*OCC_W-1:0] o_fill,
   output logic [3:0] o_cke
);
   // ------------------------------
   // burst source
   // ------------------------------
   logic [7:0] left;
   logic [7:0] pat;
   logic [OCC_W-1:0] fld;
   // cycles left in the burst
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         left <= 8'h00;
         pat <= 8'h00;
      end
      else if (i_start)
      begin
         left <= i_len;
         pat <= i_pat;
      end
      else if (o_busy)
         left <= left - 8'h01;
   end
   // idle falls back to preferred read, so a burst gives entry and exit changes
   assign o_busy = left != 8'h00;
   assign o_mode = o_busy ? pat[5:4] : 2'h0;
   assign o_rd = o_busy ? pat[1:0] : 2'h0;
   assign o_wr = o_busy ? pat[3:2] : 2'h0;
   assign o_pm = o_busy ? pat : 8'h00;
   assign o_alloc = o_busy ? pat[2:0] : 3'h0;
   assign fld = OCC_W'(pat[2:0]) + OCC_W'(1);
   assign o_fill = o_busy ? {6{fld}} : '0;
   assign o_cke = o_busy ? pat[3:0] : 4'h0;
endmodule : mcs_sched_model

// ---- testbench/testbench.sv ----
// bench: apb and burst stimulus, counters compared with computed values
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin failures++; $display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module testbench
   import mcs_pkg::*;
();
   // ------------------------------
   // signals and instances
   // ------------------------------
   logic clk = 1'b0;
   logic rst, psel, pen, pwr, start, rdy, err, irq, busy, e;
   logic [7:0] addr, pat, len, cd, um, off, pv, nv;
   logic [31:0] wd, rdat, q;
   logic [1:0] mode, rd, wr;
   logic [7:0] pm;
   logic [2:0] al;
   logic [35:0] fill;
   logic [3:0] cke;
   logic [15:0] r;
   int failures = 0;
   int num_checks = 0;
   logic [7:0] codes [14] = '{8'h04, 8'h44, 8'h45, 8'h07, 8'h50, 8'h51, 8'hea, 8'heb, 8'he3, 8'he0, 8'he7,
      8'he4, 8'h47, 8'h33};
   always #4 clk = ~clk;
   mcs_event_select #(.CNT_W(32), .OCC_W(6)) dut (.i_clock(clk), .i_rst(rst), .i_clk_en(1'b1), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_prdata(rdat),
      .o_pslverr(err), .o_irq(irq), .i_mode_ch0(mode), .i_mode_ch1(mode), .i_col_rd(rd), .i_col_wr(wr),
      .i_pre_all(rd), .i_ref_panic(rd), .i_ref_high(wr), .i_pm_cmd_sub0(pm), .i_pm_cmd_sub1(pm),
      .i_pm_rd_alloc_isochronous_request(al[0]), .i_pm_rd_alloc_norm(al[1]), .i_pm_wr_alloc(al[2]),
      .i_pm_rdq_fill(fill), .i_pm_wrq_fill(fill), .i_cke_on(cke));
   mcs_sched_model #(.OCC_W(6)) u_model (.i_clock(clk), .i_rst(rst), .i_start(start), .i_pat(pat),
      .i_len(len), .o_busy(busy), .o_mode(mode), .o_rd(rd), .o_wr(wr), .o_pm(pm), .o_alloc(al),
      .o_fill(fill), .o_cke(cke));
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   // count after a burst of n cycles of pattern p; idle mode is preferred read
   function automatic logic [31:0] exp_cnt(input logic [7:0] c, input logic [7:0] u, input logic [7:0] p,
      input logic [7:0] n);
      logic [1:0] m;
      logic h;
      logic [31:0] s;
      m = p[5:4];
      h = 1'b0;
      s = 32'h0;
      case (c)
         8'h04: h = |(u & {p[3] & m[1], p[3] & !m[1], p[2] & m[1], p[2] & !m[1], p[1] & m[1], p[1] & !m[1],
            p[0] & m[1], p[0] & !m[1]});
         8'h44: h = |(u[1:0] & p[1:0]);
         8'h45: h = |(u[5:1] & {p[3], p[1], 1'b0, p[2], p[0]});
         8'h07: h = u[m];
         8'h50, 8'h51: s = m == 2'h3 ? 32'(u[0]) + 32'(u[2]) : m == 2'h2 ? 32'(u[1]) + 32'(u[7]) :
            32'(u[4] & m[0]);
         8'hea, 8'heb: h = |(u & p);
         8'he3: h = p[0] | p[1];
         8'he7: h = p[2];
         8'he0, 8'he4: s = 32'($countones(u[5:0])) * (32'(p[2:0]) + 32'h1) * 32'(n);
         8'h47: h = |(u[3:0] & p[3:0]);
         default: h = 1'b0;
      endcase
      return h ? 32'(n) : s;
   endfunction : exp_cnt
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      q = rdat;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (n >= 20)
      begin
         `CHK(1'b0, 1'b1)
         test_done();
      end
   endtask : apb
   task automatic burst(input logic [7:0] p, input logic [7:0] n);
      int w;
      start <= 1'b1;
      pat <= p;
      len <= n;
      @(posedge clk);
      start <= 1'b0;
      w = 0;
      @(posedge clk);
      while (busy === 1'b1 && w < 300)
      begin
         @(posedge clk);
         w++;
      end
      // let the exit transition land
      repeat (2) @(posedge clk);
      if (w >= 300)
      begin
         `CHK(1'b0, 1'b1)
         test_done();
      end
   endtask : burst
   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      // reset must be high from time zero, the rest idle low
      rst = 1'b1;
      {psel, pen, pwr, start} = 4'h0;
      {addr, pat, len} = 24'h00_0000;
      wd = 32'h0000_0000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a <= 36; a += 4)
      begin
         apb(1'b0, 8'(a), 32'h0);
         `CHK(q, 32'h0)
         `CHK(e, 1'b0)
      end
      $display("test reset done");
      // edge detect alone, never with invert
      apb(1'b1, MCS_OFF_CTL0, 32'hff7f_ffff);
      apb(1'b0, MCS_OFF_CTL0, 32'h0);
      `CHK(q, 32'h0044_ffff)
      apb(1'b1, MCS_OFF_CTL0, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(e, 1'b1)
      `CHK(q, 32'h0)
      $display("test fields done");
      r = 16'h13f2;
      for (int i = 0; i < 28; i++)
      begin
         r = lfsr(r);
         um = r[7:0];
         off = {4'h0, r[13:12], 2'h0};
         r = lfsr(r);
         pv = r[7:0];
         nv = {4'h0, r[11:8]} + 8'h01;
         cd = codes[i % 14];
         // preferred read also holds between bursts, so leave it unselected
         if (cd == 8'h07)
            um[0] = 1'b0;
         apb(1'b1, MCS_OFF_CTL0 + off, {8'h00, 8'h40, um, cd});
         apb(1'b1, MCS_OFF_CNT0 + off, 32'h0);
         burst(pv, nv);
         apb(1'b0, MCS_OFF_CNT0 + off, 32'h0);
         `CHK(q, exp_cnt(cd, um, pv, nv))
         apb(1'b1, MCS_OFF_CTL0 + off, 32'h0);
      end
      $display("test events done");
      apb(1'b1, MCS_OFF_CNT0 + 8'h04, 32'hffff_ffff);
      apb(1'b1, MCS_OFF_CTL0 + 8'h04, 32'h0040_0144);
      burst(8'h01, 8'h01);
      apb(1'b0, MCS_OFF_STATUS, 32'h0);
      `CHK(q, 32'h2)
      apb(1'b1, MCS_OFF_MASK, 32'h2);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(1'b1, MCS_OFF_STATUS, 32'h2);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(1'b1, MCS_OFF_MASK, 32'h0);
      $display("test irq done");
      test_done();
   end
endmodule : testbench
